// ---- video_regs_cfg.svh ----
`ifndef VIDEO_REGS_CFG_SVH
`define VIDEO_REGS_CFG_SVH

// ==========================================================
// register indices (byte address = index * 4)
`define IDX_DAC_GAIN 8'h0B
`define IDX_DAC_LOW_POWER 8'h0D
`define IDX_CABLE_DETECT 8'h10
`define IDX_SD_READBACK 8'h12
`define IDX_LUMA_READBACK 8'h13
`define IDX_CHROMA_READBACK 8'h14
`define IDX_CTL_READBACK 8'h16
`define IDX_SOFT_RESET 8'h17
`define IDX_HD_MODE_FIRST 8'h30
`define IDX_HD_MODE_FIFTH 8'h34
`define IDX_IRQ_STATUS 8'h40
`define IDX_IRQ_MASK 8'h41

// ==========================================================
// reset values
`define RST_DAC_GAIN 8'h00
`define RST_DAC_LOW_POWER 3'h0
`define RST_AUTO_PWDN 1'h0
`define RST_HD_MODE_FIRST 8'h00
`define RST_HSYNC_FIELD_SEL 1'h1
`define RST_IRQ_MASK 3'h0

// ==========================================================
// field positions
`define BIT_AUTO_PWDN 4
`define BIT_SOFT_RESET 1
`define BIT_EMBEDDED_SYNC 2
`define BIT_HSYNC_FIELD_SEL 6
`define MSB_OUT_STD 1
`define LSB_OUT_STD 0
`define MSB_INPUT_MODE 7
`define LSB_INPUT_MODE 3

// ==========================================================
// gain decode
`define GAIN_FULL_STEPS 7'h40
`define GAIN_NEG_BIT 7
`define GAIN_SAT_BIT 6

// ==========================================================
// interrupt status bits
`define IRQ_CABLE1 0
`define IRQ_CABLE2 1
`define IRQ_BAD_MODE 2

`endif

// ---- video_regs_pkg.sv ----
package video_regs_pkg;

  // output level standard selected in the first mode register
  typedef enum logic [1:0] {
    OUT_STD_EIA_770_23 = 2'h0,
    OUT_STD_EIA_770_1 = 2'h1,
    OUT_STD_FULL_RANGE = 2'h2,
    OUT_STD_RESERVED = 2'h3
  } out_std_t;

  // coarse class of the selected input format
  typedef enum logic [2:0] {
    FMT_ED = 3'h0,
    FMT_NONSTD = 3'h1,
    FMT_720P = 3'h2,
    FMT_INTERLACED = 3'h3,
    FMT_1080P = 3'h4,
    FMT_1080PSF = 3'h5,
    FMT_RESERVED = 3'h6
  } fmt_class_t;

endpackage : video_regs_pkg

// ---- gain_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// gain code from the register file and its decoded form
interface gain_if;
  logic [7:0] code;
  logic negative;
  logic [6:0] steps;

  modport regs (output code, input negative, input steps);
  modport decoder (input code, output negative, output steps);
endinterface : gain_if

`default_nettype wire

// ---- pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none

// two-flop synchroniser for pin levels; only stage two is read outside
module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] level_out
);
  logic [WIDTH-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_reg <= '0;
      level_out <= '0;
    end
    else
    begin
      meta_reg <= pin_in;
      level_out <= meta_reg;
    end
  end
endmodule : pin_sync

`default_nettype wire

// ---- dac_gain_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_regs_cfg.svh"

// turns the output level code into sign and step count, registered
module dac_gain_decode (
  input wire logic clk_sys,
  input wire logic rst_n,
  gain_if.decoder gain
);
  import video_regs_pkg::*;

  // top bit set: negative, 0xC0 is full scale (64 steps), 0xFF one step
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      gain.negative <= 1'b0;
      gain.steps <= 7'h00;
    end
    else if (gain.code[`GAIN_NEG_BIT])
    begin
      gain.negative <= 1'b1;
      gain.steps <= `GAIN_FULL_STEPS - {1'b0, gain.code[5:0]};
    end
    else
    begin
      gain.negative <= 1'b0;
      // codes 0x40 to 0x7F saturate at full positive scale
      gain.steps <= gain.code[`GAIN_SAT_BIT] ? `GAIN_FULL_STEPS
                                             : {1'b0, gain.code[5:0]};
    end
  end
endmodule : dac_gain_decode

`default_nettype wire

// ---- video_encoder_dac_status_mode_regs.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_regs_cfg.svh"

module video_encoder_dac_status_mode_regs (
  input wire logic clk_sys,
  input wire logic rst_n,
  // classic wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // pins from the video source and the analog front end
  input wire logic [7:0] sd_pix_pin,
  input wire logic [7:0] luma_pix_pin,
  input wire logic [7:0] chroma_pix_pin,
  input wire logic pix_blank_pin,
  input wire logic pix_vsync_pin,
  input wire logic pix_hsync_pin,
  input wire logic sd_vsync_pin,
  input wire logic sd_hsync_pin,
  input wire logic lock_or_serial_out_pin,
  input wire logic [1:0] dac_unconnected_pin,
  // control toward the encoder core
  output logic gain_negative,
  output logic [6:0] gain_steps,
  output logic [2:0] dac_low_power,
  output logic [1:0] dac_auto_off,
  output video_regs_pkg::out_std_t out_std,
  output logic embedded_sync,
  output logic hsync_field_sel,
  output logic [4:0] input_mode,
  output video_regs_pkg::fmt_class_t fmt_class,
  output logic soft_reset_pulse,
  output logic irq
);
  import video_regs_pkg::*;

  // ==========================================================
  // pin synchronisation
  localparam int PIN_W = 32;
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_lvl;
  logic [7:0] sd_lvl;
  logic [7:0] luma_lvl;
  logic [7:0] chroma_lvl;
  logic [5:0] ctl_lvl;
  logic [1:0] unconn_lvl;

  // one wide synchroniser; bus bits may tear but the readback is advisory
  assign pin_raw = {dac_unconnected_pin, lock_or_serial_out_pin, sd_hsync_pin, sd_vsync_pin,
                    pix_hsync_pin, pix_vsync_pin, pix_blank_pin,
                    chroma_pix_pin, luma_pix_pin, sd_pix_pin};

  pin_sync #(
    .WIDTH(PIN_W)
  ) u_pin_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(pin_raw),
    .level_out(pin_lvl)
  );

  assign sd_lvl = pin_lvl[7:0];
  assign luma_lvl = pin_lvl[15:8];
  assign chroma_lvl = pin_lvl[23:16];
  assign ctl_lvl = pin_lvl[29:24];
  assign unconn_lvl = pin_lvl[31:30];

  // ==========================================================
  // bus decode
  logic [7:0] idx;
  logic req;
  logic wr_fire;
  logic wr_lane0;
  logic [7:0] wdat;
  logic ack_reg;

  assign idx = wb_adr_i[9:2];
  assign req = wb_cyc_i && wb_stb_i && !ack_reg;
  assign wr_fire = req && wb_we_i;
  assign wr_lane0 = wr_fire && wb_sel_i[0];
  assign wdat = wb_dat_i[7:0];

  // one wait state: ack in the cycle after the request is seen
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  assign wb_ack_o = ack_reg;

  // ==========================================================
  // software reset
  logic sw_rst_reg;

  // pulses for one cycle, then clears itself
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      sw_rst_reg <= 1'b0;
    else
      sw_rst_reg <= wr_lane0 && (idx == `IDX_SOFT_RESET) && wdat[`BIT_SOFT_RESET];
  end

  assign soft_reset_pulse = sw_rst_reg;

  // ==========================================================
  // writable registers
  logic [7:0] gain_code_reg;
  logic [2:0] low_power_reg;
  logic auto_pwdn_reg;
  logic [7:0] mode_first_reg;
  logic field_sel_reg;
  logic [2:0] irq_mask_reg;

  // gain code; every register below also falls back on a soft reset
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      gain_code_reg <= `RST_DAC_GAIN;
    else if (sw_rst_reg)
      gain_code_reg <= `RST_DAC_GAIN;
    else if (wr_lane0 && idx == `IDX_DAC_GAIN)
      gain_code_reg <= wdat;
  end

  // per-DAC low power enables
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      low_power_reg <= `RST_DAC_LOW_POWER;
    else if (sw_rst_reg)
      low_power_reg <= `RST_DAC_LOW_POWER;
    else if (wr_lane0 && idx == `IDX_DAC_LOW_POWER)
      low_power_reg <= wdat[2:0];
  end

  // auto power-down enable, the only writable cable-detect bit
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      auto_pwdn_reg <= `RST_AUTO_PWDN;
    else if (sw_rst_reg)
      auto_pwdn_reg <= `RST_AUTO_PWDN;
    else if (wr_lane0 && idx == `IDX_CABLE_DETECT)
      auto_pwdn_reg <= wdat[`BIT_AUTO_PWDN];
  end

  // first mode register, stored whole
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      mode_first_reg <= `RST_HD_MODE_FIRST;
    else if (sw_rst_reg)
      mode_first_reg <= `RST_HD_MODE_FIRST;
    else if (wr_lane0 && idx == `IDX_HD_MODE_FIRST)
      mode_first_reg <= wdat;
  end

  // sync pair selection held in the fifth mode register
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      field_sel_reg <= `RST_HSYNC_FIELD_SEL;
    else if (sw_rst_reg)
      field_sel_reg <= `RST_HSYNC_FIELD_SEL;
    else if (wr_lane0 && idx == `IDX_HD_MODE_FIFTH)
      field_sel_reg <= wdat[`BIT_HSYNC_FIELD_SEL];
  end

  // interrupt mask
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_mask_reg <= `RST_IRQ_MASK;
    else if (sw_rst_reg)
      irq_mask_reg <= `RST_IRQ_MASK;
    else if (wr_lane0 && idx == `IDX_IRQ_MASK)
      irq_mask_reg <= wdat[2:0];
  end

  // ==========================================================
  // gain decoding
  gain_if gain_bus ();

  assign gain_bus.code = gain_code_reg;

  dac_gain_decode u_gain_decode (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .gain(gain_bus.decoder)
  );

  // decoder outputs are flip-flops already
  assign gain_negative = gain_bus.negative;
  assign gain_steps = gain_bus.steps;

  // ==========================================================
  // DAC power control
  // DAC 3 has no detector, so it is never powered down automatically
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dac_low_power <= 3'h0;
      dac_auto_off <= 2'h0;
    end
    else
    begin
      dac_low_power <= low_power_reg;
      dac_auto_off <= auto_pwdn_reg ? unconn_lvl : 2'h0;
    end
  end

  // ==========================================================
  // mode decoding
  logic [4:0] mode_code;
  fmt_class_t fmt_next;

  assign mode_code = mode_first_reg[`MSB_INPUT_MODE:`LSB_INPUT_MODE];

  // class of format; reserved codes are flagged, not acted on
  always_comb
  begin
    unique case (mode_code)
      5'h00, 5'h02, 5'h03, 5'h04: fmt_next = FMT_ED;
      5'h01: fmt_next = FMT_NONSTD;
      5'h05, 5'h06, 5'h07, 5'h08, 5'h09: fmt_next = FMT_720P;
      5'h0A, 5'h0D, 5'h0E: fmt_next = FMT_INTERLACED;
      5'h0F, 5'h10, 5'h11: fmt_next = FMT_1080P;
      5'h12: fmt_next = FMT_1080PSF;
      default: fmt_next = FMT_RESERVED;
    endcase
  end

  // mode outputs toward the timing and output stages
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_std <= OUT_STD_EIA_770_23;
      embedded_sync <= 1'b0;
      hsync_field_sel <= `RST_HSYNC_FIELD_SEL;
      input_mode <= 5'h00;
      fmt_class <= FMT_ED;
    end
    else
    begin
      out_std <= out_std_t'(mode_first_reg[`MSB_OUT_STD:`LSB_OUT_STD]);
      embedded_sync <= mode_first_reg[`BIT_EMBEDDED_SYNC];
      hsync_field_sel <= field_sel_reg;
      input_mode <= mode_code;
      fmt_class <= fmt_next;
    end
  end

  // ==========================================================
  // interrupts
  logic [1:0] unconn_prev_reg;
  logic [2:0] irq_event;
  logic [2:0] irq_status_reg;
  logic [2:0] irq_clear;

  // previous cable level, for change detection
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      unconn_prev_reg <= 2'h0;
    else
      unconn_prev_reg <= unconn_lvl;
  end

  assign irq_event[`IRQ_CABLE1] = unconn_lvl[0] ^ unconn_prev_reg[0];
  assign irq_event[`IRQ_CABLE2] = unconn_lvl[1] ^ unconn_prev_reg[1];
  // a reserved input mode was written; software should never do this
  assign irq_event[`IRQ_BAD_MODE] = wr_lane0 && (idx == `IDX_HD_MODE_FIRST) &&
                                    (wdat[7:3] == 5'h0B || wdat[7:3] == 5'h0C ||
                                     wdat[7:3] >= 5'h13);
  assign irq_clear = (wr_lane0 && idx == `IDX_IRQ_STATUS) ? wdat[2:0] : 3'h0;

  // write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq_status_reg <= 3'h0;
    else if (sw_rst_reg)
      irq_status_reg <= 3'h0;
    else
      irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
  end

  // level interrupt, registered
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      irq <= 1'b0;
    else
      irq <= |(irq_status_reg & irq_mask_reg);
  end

  // ==========================================================
  // read path
  logic [7:0] rdat;

  // reserved bits read zero; unmapped indices read zero and still ack
  always_comb
  begin
    rdat = 8'h00;
    unique case (idx)
      `IDX_DAC_GAIN: rdat = gain_code_reg;
      `IDX_DAC_LOW_POWER: rdat = {5'h00, low_power_reg};
      `IDX_CABLE_DETECT: rdat = {3'h0, auto_pwdn_reg, 2'h0, unconn_lvl};
      `IDX_SD_READBACK: rdat = sd_lvl;
      `IDX_LUMA_READBACK: rdat = luma_lvl;
      `IDX_CHROMA_READBACK: rdat = chroma_lvl;
      `IDX_CTL_READBACK: rdat = {2'h0, ctl_lvl};
      `IDX_SOFT_RESET: rdat = {6'h00, sw_rst_reg, 1'b0};
      `IDX_HD_MODE_FIRST: rdat = mode_first_reg;
      `IDX_HD_MODE_FIFTH: rdat = {1'b0, field_sel_reg, 6'h00};
      `IDX_IRQ_STATUS: rdat = {5'h00, irq_status_reg};
      `IDX_IRQ_MASK: rdat = {5'h00, irq_mask_reg};
      default: rdat = 8'h00;
    endcase
  end

  // read data registered with the ack
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      wb_dat_o <= 32'h0000_0000;
    else if (req && !wb_we_i)
      wb_dat_o <= {24'h00_0000, rdat};
  end

endmodule : video_encoder_dac_status_mode_regs

`default_nettype wire

// ---- video_pins_source.sv ----
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// video source model: pins follow a pattern chosen by the bench
module video_pins_source (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] pattern,
  output logic [7:0] sd_pix_pin,
  output logic [7:0] luma_pix_pin,
  output logic [7:0] chroma_pix_pin,
  output logic pix_blank_pin,
  output logic pix_vsync_pin,
  output logic pix_hsync_pin,
  output logic sd_vsync_pin,
  output logic sd_hsync_pin,
  output logic lock_or_serial_out_pin,
  output logic [1:0] dac_unconnected_pin
);
  logic [7:0] p_reg;

  // pins move just after an edge, as from a source on its own pixel clock
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
      p_reg <= 8'h00;
    else
      p_reg <= pattern;
  end

  // each bus gets a different image of the pattern so swapped buses show up
  assign sd_pix_pin = p_reg;
  assign luma_pix_pin = ~p_reg;
  assign chroma_pix_pin = {p_reg[3:0], p_reg[7:4]};
  assign pix_blank_pin = p_reg[0];
  assign pix_vsync_pin = p_reg[1];
  assign pix_hsync_pin = p_reg[2];
  assign sd_vsync_pin = p_reg[3];
  assign sd_hsync_pin = p_reg[4];
  assign lock_or_serial_out_pin = p_reg[5];
  assign dac_unconnected_pin = p_reg[1:0];
endmodule : video_pins_source

`default_nettype wire

// ---- video_encoder_dac_status_mode_regs_checker.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_regs_cfg.svh"

// ==========================================================
// port relations of the register block
module video_encoder_dac_status_mode_regs_checker (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic gain_negative,
  input wire logic [6:0] gain_steps,
  input wire logic [2:0] dac_low_power,
  input wire logic [1:0] dac_auto_off,
  input wire video_regs_pkg::out_std_t out_std,
  input wire logic embedded_sync,
  input wire logic hsync_field_sel,
  input wire logic [4:0] input_mode,
  input wire logic soft_reset_pulse,
  input wire logic irq
);
  import video_regs_pkg::*;
  logic take;
  logic wr;
  logic [7:0] idx;
  logic [7:0] d1_reg, d2_reg, d3_reg;
  logic [6:0] steps3;

  // a request is taken on an edge with strobe up and ack low
  assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr = take && wb_we_i && wb_sel_i[0];
  assign idx = wb_adr_i[9:2];
  assign steps3 = d3_reg[7] ? 7'h40 - {1'h0, d3_reg[5:0]} : (d3_reg[6] ? 7'h40 : {1'h0, d3_reg[5:0]});

  // write data three edges back, so outputs can be tied to what was written
  always_ff @(posedge clk_sys or negedge rst_n)
  begin
    if (!rst_n)
    begin
      d1_reg <= 8'h00;
      d2_reg <= 8'h00;
      d3_reg <= 8'h00;
    end
    else
    begin
      d1_reg <= wb_dat_i[7:0];
      d2_reg <= d1_reg;
      d3_reg <= d2_reg;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  AST_ACK_WAIT: assert property (take |=> wb_ack_o) else $error("ack missing after request");
  AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  AST_LOW_POWER: assert property (wr && idx == `IDX_DAC_LOW_POWER |-> ##3 dac_low_power == d3_reg[2:0]) else $error("low power enables differ");
  AST_GAIN: assert property (wr && idx == `IDX_DAC_GAIN |-> ##3 gain_negative == d3_reg[7] && gain_steps == steps3) else $error("gain decode wrong");
  AST_AUTO_OFF: assert property (wr && idx == `IDX_CABLE_DETECT && !wb_dat_i[4] |-> ##3 (dac_auto_off == 2'h0) [*3]) else $error("auto power-down active");
  AST_CTL_RSVD: assert property (take && !wb_we_i && idx == `IDX_CTL_READBACK |=> wb_dat_o[31:6] == 26'h0) else $error("control readback top bits set");
  AST_SOFT_PULSE: assert property (wr && idx == `IDX_SOFT_RESET && wb_dat_i[1] |-> ##[1:2] $rose(soft_reset_pulse)) else $error("soft reset pulse missing");
  AST_SOFT_CLEAR: assert property (soft_reset_pulse |-> ##4 dac_low_power == 3'h0 && input_mode == 5'h00 && out_std == OUT_STD_EIA_770_23 && hsync_field_sel && !irq) else $error("soft reset left state");
  AST_MODE: assert property (wr && idx == `IDX_HD_MODE_FIRST |-> ##3 out_std == d3_reg[1:0] && embedded_sync == d3_reg[2] && input_mode == d3_reg[7:3]) else $error("mode fields differ");
  AST_FIELD_SEL: assert property (wr && idx == `IDX_HD_MODE_FIFTH |-> ##3 hsync_field_sel == d3_reg[6]) else $error("sync pair select differs");
  AST_IRQ_MASK: assert property (wr && idx == `IDX_IRQ_MASK && wb_dat_i[2:0] == 3'h0 |-> ##3 !irq [*2]) else $error("irq with all masked");

  COV_SOFT: cover property (soft_reset_pulse);
  COV_IRQ: cover property ($rose(irq));
  COV_GAIN_NEG: cover property (gain_negative && gain_steps == 7'h40);
endmodule : video_encoder_dac_status_mode_regs_checker

bind video_encoder_dac_status_mode_regs video_encoder_dac_status_mode_regs_checker chk_u (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gain_negative, .gain_steps, .dac_low_power, .dac_auto_off, .out_std, .embedded_sync, .hsync_field_sel, .input_mode, .soft_reset_pulse, .irq);

`default_nettype wire

// ---- video_encoder_dac_status_mode_regs_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "video_regs_cfg.svh"

module video_encoder_dac_status_mode_regs_tb_top;
  import video_regs_pkg::*;
  logic clk_sys, rst_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [9:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rd;
  logic [7:0] pattern, sd_pix_pin, luma_pix_pin, chroma_pix_pin;
  logic pix_blank_pin, pix_vsync_pin, pix_hsync_pin, sd_vsync_pin, sd_hsync_pin;
  logic lock_or_serial_out_pin, gain_negative, embedded_sync, hsync_field_sel;
  logic soft_reset_pulse, irq;
  logic [1:0] dac_unconnected_pin, dac_auto_off;
  logic [6:0] gain_steps;
  logic [2:0] dac_low_power;
  logic [4:0] input_mode;
  out_std_t out_std;
  fmt_class_t fmt_class;
  int err_count = 0;
  int n_checks = 0;
  logic [7:0] gcode [6] = '{8'hC0, 8'hFF, 8'h40, 8'h3F, 8'h82, 8'h00};
  logic [7:0] gexp [6] = '{8'hC0, 8'h81, 8'h40, 8'h3F, 8'hBE, 8'h00};

  video_encoder_dac_status_mode_regs dut_u (.clk_sys, .rst_n, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .sd_pix_pin, .luma_pix_pin,
    .chroma_pix_pin, .pix_blank_pin, .pix_vsync_pin, .pix_hsync_pin, .sd_vsync_pin,
    .sd_hsync_pin, .lock_or_serial_out_pin, .dac_unconnected_pin, .gain_negative, .gain_steps,
    .dac_low_power, .dac_auto_off, .out_std, .embedded_sync, .hsync_field_sel, .input_mode,
    .fmt_class, .soft_reset_pulse, .irq);
  video_pins_source src_u (.clk_sys, .rst_n, .pattern, .sd_pix_pin, .luma_pix_pin,
    .chroma_pix_pin, .pix_blank_pin, .pix_vsync_pin, .pix_hsync_pin, .sd_vsync_pin,
    .sd_hsync_pin, .lock_or_serial_out_pin, .dac_unconnected_pin);

  // 40 MHz system clock
  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ==========================================================
  // helpers
  function automatic fmt_class_t fexp(input int c);
    if (c == 1) return FMT_NONSTD;
    if (c <= 4) return FMT_ED;
    if (c <= 9) return FMT_720P;
    if (c == 10 || c == 13 || c == 14) return FMT_INTERLACED;
    if (c >= 15 && c <= 17) return FMT_1080P;
    if (c == 18) return FMT_1080PSF;
    return FMT_RESERVED;
  endfunction : fexp

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // one classic cycle; held until ack is sampled, so no wait count is assumed
  task automatic xfer(input logic we, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_sel_i <= 4'hF;
    wb_adr_i <= {idx, 2'h0};
    wb_dat_i <= {24'h0, wd};
    n = 0;
    do
    begin
      @(posedge clk_sys);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 20);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1)
    begin
      err_count++;
      conclude();
    end
  endtask : xfer

  task automatic rdchk(input string name, input logic [7:0] idx, input logic [31:0] exp);
    xfer(1'b0, idx, 8'h00);
    check(name, rd, exp);
  endtask : rdchk

  // long enough for synchronisers and registered outputs to land
  task automatic settle();
    repeat (6) @(posedge clk_sys);
  endtask : settle

  // ==========================================================
  // main sequence
  initial
  begin
    rst_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 10'h000;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0;
    pattern = 8'h00;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    settle();
    check("field sel", {31'h0, hsync_field_sel}, 32'h1);
    rdchk("gain", `IDX_DAC_GAIN, 32'h0);
    rdchk("low power", `IDX_DAC_LOW_POWER, 32'h0);
    rdchk("soft reset", `IDX_SOFT_RESET, 32'h0);
    rdchk("mode", `IDX_HD_MODE_FIRST, 32'h0);
    xfer(1'b1, `IDX_DAC_LOW_POWER, 8'h05);
    rdchk("low power", `IDX_DAC_LOW_POWER, 32'h5);
    xfer(1'b1, `IDX_HD_MODE_FIFTH, 8'h00);
    xfer(1'b1, 8'h20, 8'hFF);
    rdchk("unmapped", 8'h20, 32'h0);
    settle();
    check("low power out", {29'h0, dac_low_power}, 32'h5);
    check("field sel", {31'h0, hsync_field_sel}, 32'h0);
    for (int i = 0; i < 6; i++)
    begin
      xfer(1'b1, `IDX_DAC_GAIN, gcode[i]);
      settle();
      check("gain", {24'h0, gain_negative, gain_steps}, {24'h0, gexp[i]});
    end
    // every defined input mode, reserved codes left out
    for (int c = 0; c < 19; c++)
    begin
      if (c == 11 || c == 12)
        continue;
      xfer(1'b1, `IDX_HD_MODE_FIRST, {c[4:0], c[0], 2'(c % 3)});
      settle();
      check("mode", {24'h0, input_mode, embedded_sync, out_std}, {24'h0, c[4:0], c[0], 2'(c % 3)});
      check("format", {29'h0, fmt_class}, {29'h0, fexp(c)});
    end
    for (int k = 0; k < 2; k++)
    begin
      pattern <= k ? 8'h5A : 8'hA5;
      settle();
      rdchk("sd bus", `IDX_SD_READBACK, {24'h0, pattern});
      rdchk("luma bus", `IDX_LUMA_READBACK, {24'h0, ~pattern});
      rdchk("chroma bus", `IDX_CHROMA_READBACK, {24'h0, pattern[3:0], pattern[7:4]});
      rdchk("ctl pins", `IDX_CTL_READBACK, {26'h0, pattern[5:0]});
    end
    // cable events, auto power-down and the interrupt
    pattern <= 8'h00;
    settle();
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h07);
    xfer(1'b1, `IDX_IRQ_MASK, 8'h03);
    settle();
    check("irq idle", {31'h0, irq}, 32'h0);
    pattern <= 8'h03;
    settle();
    check("irq set", {31'h0, irq}, 32'h1);
    rdchk("irq status", `IDX_IRQ_STATUS, 32'h3);
    xfer(1'b0, `IDX_CABLE_DETECT, 8'h00);
    check("cable", rd & 32'h3, 32'h3);
    xfer(1'b1, `IDX_CABLE_DETECT, 8'h10);
    settle();
    check("auto off", {30'h0, dac_auto_off}, 32'h3);
    xfer(1'b1, `IDX_CABLE_DETECT, 8'h00);
    xfer(1'b1, `IDX_IRQ_MASK, 8'h00);
    settle();
    check("auto off", {30'h0, dac_auto_off}, 32'h0);
    check("irq masked", {31'h0, irq}, 32'h0);
    xfer(1'b1, `IDX_IRQ_MASK, 8'h07);
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h03);
    xfer(1'b1, `IDX_HD_MODE_FIRST, 8'h58);
    settle();
    check("format", {29'h0, fmt_class}, {29'h0, FMT_RESERVED});
    rdchk("irq status", `IDX_IRQ_STATUS, 32'h4);
    xfer(1'b1, `IDX_IRQ_STATUS, 8'h04);
    settle();
    check("irq clear", {31'h0, irq}, 32'h0);
    // soft reset returns writable state to defaults
    xfer(1'b1, `IDX_DAC_LOW_POWER, 8'h07);
    xfer(1'b1, `IDX_HD_MODE_FIRST, 8'h2A);
    xfer(1'b1, `IDX_SOFT_RESET, 8'h02);
    settle();
    rdchk("low power", `IDX_DAC_LOW_POWER, 32'h0);
    rdchk("mode", `IDX_HD_MODE_FIRST, 32'h0);
    rdchk("soft reset", `IDX_SOFT_RESET, 32'h0);
    rdchk("fifth mode", `IDX_HD_MODE_FIFTH, 32'h40);
    check("low power out", {29'h0, dac_low_power}, 32'h0);
    conclude();
  end
endmodule : video_encoder_dac_status_mode_regs_tb_top

`default_nettype wire
